/* File: hw/vfs_regs.sv */
`timescale 1ns/10ps
`include "vfs_map.svh"
// Contract
// R1: Commanded output never goes below floor; vout ramps up to a raised floor one step per clock.
// R2: Floor is 12 bits, upper four read zero.
// R3: Detect target below floor while converting.
// R4: On warning, ramp target to floor.
// R5: Warning sets three status bits.
// R6: Warning notifies host.
// R7: Floor above target gives same response.
// R8: Out-of-range floor write is invalid data.
// R9: Frequency exponent fixed at plus seven.
// R10: Bits 10:4 zero, 3:0 writable mantissa.
// R11: Mantissa maps to table frequency.
// R12: Startup value from memory or strap.
// R13: Strap limited to four frequencies.
// R14: Unsupported frequency write is invalid data.
// R15: Scale mantissa 8 to 15 restores 8.
// R16: Frequency change on the fly; read returns write.
module vfs_regs (
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] cmd_in,
    input wire logic [15:0] wdata_in,
    input wire logic converting_in,
    input wire logic [11:0] target_in,
    input wire logic [11:0] nvm_floor_in,
    input wire logic [3:0] nvm_freq_in,
    input wire logic use_strap_in,
    input wire logic [3:0] second_strap_selector_in,
    input wire logic [3:0] scale_mant_in,
    output logic [15:0] rdata_out,
    output logic [11:0] vout_cmd_out,
    output logic ramp_out,
    output vfs_pkg::vfs_freq_type freq_out,
    output vfs_pkg::vfs_status_type status_out,
    output logic notify_out,
    output logic [3:0] scale_restore_out
);
    logic [3:0] s1_q;
    logic [3:0] s2_q;
    logic [3:0] s3_q;
    logic [3:0] strap_held_q;
    logic [3:0] strap_held_d;
    logic [2:0] settle_q;
    logic [2:0] settle_d;
    vfs_pkg::vfs_startup_type state_q;
    vfs_pkg::vfs_startup_type state_d;
    logic [11:0] floor_q;
    logic [11:0] floor_d;
    logic [3:0] freq_q;
    logic [3:0] freq_d;
    logic strap_mode_q;
    logic strap_mode_d;
    logic [11:0] vout_q;
    logic [11:0] vout_d;
    logic ramp_q;
    logic ramp_d;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    vfs_pkg::vfs_status_type status_q;
    logic notify_q;
    logic notify_d;
    logic pend_q;
    logic pend_d;
    logic [3:0] restore_q;
    logic [3:0] restore_d;

    wire logic sel_floor;
    wire logic sel_freq;
    wire logic wr_floor;
    wire logic wr_freq;
    wire logic rd_floor;
    wire logic rd_freq;
    wire logic floor_hi_bad;
    wire logic floor_range_bad;
    wire logic floor_bad;
    wire logic floor_ok;
    wire logic freq_bad;
    wire logic freq_ok;
    wire logic invalid_any;
    wire logic below;
    wire logic warn;
    wire logic warn_new;
    wire logic notify_req;
    wire logic [11:0] clamp_tgt;
    wire logic step_up;
    wire logic step_down;
    wire logic strap_ok;
    wire logic [3:0] strap_val;
    wire logic settle_done;
    wire logic load_now;
    wire logic loading;
    wire logic running;
    wire logic [3:0] start_freq;
    wire logic [15:0] floor_word;
    wire logic [15:0] freq_word;
    wire logic scale_hi;
    wire logic [3:0] status_d;

    // Compares a command code against one register offset.
    function automatic logic cmd_hit(input logic [7:0] code, input logic [7:0] offset);
        return code == offset;
    endfunction : cmd_hit

    // Command decode.
    assign sel_floor = cmd_hit(cmd_in, `VFS_FLOOR_OFFSET);
    assign sel_freq = cmd_hit(cmd_in, `VFS_FREQ_OFFSET);
    assign wr_floor = wr_in && sel_floor;
    assign wr_freq = wr_in && sel_freq;
    assign rd_floor = rd_in && sel_floor;
    assign rd_freq = rd_in && sel_freq;

    // Write validity checks.
    assign floor_hi_bad = wdata_in[15:12] != 4'h0; // R2
    assign floor_range_bad = wdata_in[11:0] < `VFS_FLOOR_VALID_MIN ||
        wdata_in[11:0] > `VFS_FLOOR_VALID_MAX; // R8
    assign floor_bad = wr_floor && (floor_hi_bad || floor_range_bad); // R8
    assign floor_ok = wr_floor && !floor_bad;
    assign freq_bad = wr_freq && wdata_in[15:4] != {`VFS_FREQ_EXP, 7'h00}; // R14
    assign freq_ok = wr_freq && !freq_bad;
    assign invalid_any = floor_bad || freq_bad;

    // Floor comparison and clamp.
    assign below = target_in < floor_q; // R3 R7
    assign warn = converting_in && below; // R3
    assign warn_new = warn && !status_q.vout_minmax_warn; // R6
    assign clamp_tgt = below ? floor_q : target_in; // R1
    assign step_up = vout_q < clamp_tgt;
    assign step_down = vout_q > clamp_tgt;

    // Strap passes three flops; a value counts once the last two agree.
    assign strap_ok = s2_q == s3_q;
    assign strap_held_d = strap_ok ? s3_q : strap_held_q;
    assign strap_val = strap_held_q;

    // Start-up sequencing.
    assign settle_done = settle_q == 3'h7;
    assign settle_d = settle_done ? settle_q : settle_q + 3'h1;
    assign load_now = settle_done && (strap_ok || !use_strap_in);
    assign loading = state_q == vfs_pkg::VFS_ST_LOAD && load_now;
    assign running = state_q == vfs_pkg::VFS_ST_RUN;
    assign start_freq = use_strap_in ? strap_val : nvm_freq_in; // R12

    // Read data words.
    assign floor_word = {4'h0, floor_q}; // R2
    assign freq_word = {`VFS_FREQ_EXP, 7'h00, freq_q}; // R9 R10

    // Status, notification and scale restore next values.
    genvar gi;
    generate
        for (gi = 1; gi < 4; gi++) begin : g_warn_bit
            assign status_d[gi] = status_q[gi] | warn; // R5
        end
    endgenerate
    assign status_d[0] = status_q[0] | invalid_any; // R8 R14
    assign notify_req = warn_new || invalid_any; // R6 R8 R14
    // A second event during a pulse waits one cycle, so pulses never merge.
    assign notify_d = !notify_q && (notify_req || pend_q); // R6
    assign pend_d = notify_q && (notify_req || pend_q);
    assign scale_hi = scale_mant_in >= `VFS_SCALE_RESTORE_HI;
    assign restore_d = scale_hi ? `VFS_SCALE_RESTORE_HI : 4'h0; // R15

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            vfs_pkg::VFS_ST_WAIT: begin
                if (settle_done) begin
                    state_d = vfs_pkg::VFS_ST_LOAD;
                end
            end
            vfs_pkg::VFS_ST_LOAD: begin
                if (load_now) begin
                    state_d = vfs_pkg::VFS_ST_RUN;
                end
            end
            vfs_pkg::VFS_ST_RUN: begin
                state_d = vfs_pkg::VFS_ST_RUN;
            end
            default: begin
                state_d = vfs_pkg::VFS_ST_WAIT;
            end
        endcase
    end

    always_comb begin
        freq_d = freq_q;
        strap_mode_d = strap_mode_q;
        if (loading) begin
            freq_d = start_freq; // R12
            strap_mode_d = use_strap_in; // R13
        end else if (running && freq_ok) begin
            freq_d = wdata_in[3:0]; // R16
            strap_mode_d = 1'b0;
        end
    end

    always_comb begin
        floor_d = floor_q;
        if (!running) begin
            floor_d = nvm_floor_in;
        end else if (floor_ok) begin
            floor_d = wdata_in[11:0]; // R2
        end
    end

    // Output target moves one step per clock toward the clamped target.
    always_comb begin
        vout_d = vout_q;
        ramp_d = 1'b0;
        if (step_up) begin
            vout_d = vout_q + 12'h001; // R4
            ramp_d = 1'b1;
        end else if (step_down) begin
            vout_d = vout_q - 12'h001; // R4
            ramp_d = 1'b1;
        end
    end

    always_comb begin
        rdata_d = rdata_q;
        if (rd_floor) begin
            rdata_d = floor_word; // R2
        end else if (rd_freq) begin
            rdata_d = freq_word; // R9 R10
        end else if (rd_in) begin
            rdata_d = 16'h0000;
        end
    end

    always_ff @(posedge clock_in) begin
        s1_q <= second_strap_selector_in;
        s2_q <= s1_q;
        s3_q <= s2_q;
        strap_held_q <= strap_held_d;
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            settle_q <= 3'h0;
        end else begin
            settle_q <= settle_d;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            state_q <= vfs_pkg::VFS_ST_WAIT;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            floor_q <= `VFS_FLOOR_RESET;
        end else begin
            floor_q <= floor_d;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            freq_q <= `VFS_FREQ_RESET;
        end else begin
            freq_q <= freq_d;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            strap_mode_q <= 1'b0;
        end else begin
            strap_mode_q <= strap_mode_d;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            vout_q <= `VFS_FLOOR_RESET;
        end else begin
            vout_q <= vout_d;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            ramp_q <= 1'b0;
        end else begin
            ramp_q <= ramp_d;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            status_q <= 4'h0;
        end else begin
            status_q <= status_d;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            notify_q <= 1'b0;
        end else begin
            notify_q <= notify_d;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            pend_q <= 1'b0;
        end else begin
            pend_q <= pend_d;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            restore_q <= 4'h0;
        end else begin
            restore_q <= restore_d;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            rdata_q <= 16'h0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    vfs_freq_decode u_dec (
        .clock_in(clock_in),
        .nrst_in(nrst_in),
        .mant_in(freq_q),
        .strap_in(strap_mode_q),
        .freq_out(freq_out)
    );
    assign rdata_out = rdata_q;
    assign vout_cmd_out = vout_q;
    assign ramp_out = ramp_q;
    assign status_out = status_q;
    assign notify_out = notify_q;
    assign scale_restore_out = restore_q;
endmodule : vfs_regs

/* File: hw/vfs_map.svh */
`ifndef VFS_MAP_SVH
`define VFS_MAP_SVH
`define VFS_FLOOR_OFFSET 8'h2B
`define VFS_FREQ_OFFSET 8'h33
`define VFS_FLOOR_MSB 11
`define VFS_FREQ_EXP 5'h07
`define VFS_FLOOR_RESET 12'h000
`define VFS_FREQ_RESET 4'h7
`define VFS_FLOOR_VALID_MIN 12'h000
`define VFS_FLOOR_VALID_MAX 12'hFFF
`define VFS_SCALE_RESTORE_HI 4'h8
`define VFS_FREQ_LO_OK 4'h4
`endif

/* File: hw/vfs_pkg.sv */
package vfs_pkg;
    typedef enum logic [7:0] {
        VFS_F0P4 = 8'h01,
        VFS_F0P6 = 8'h02,
        VFS_F0P8 = 8'h04,
        VFS_F1P0 = 8'h08,
        VFS_F1P2 = 8'h10,
        VFS_F1P4 = 8'h20,
        VFS_F1P8 = 8'h40,
        VFS_F2P0 = 8'h80
    } vfs_freq_type;
    typedef enum logic [2:0] {
        VFS_ST_WAIT = 3'h1,
        VFS_ST_LOAD = 3'h2,
        VFS_ST_RUN = 3'h4
    } vfs_startup_type;
    typedef struct packed {
        logic none_of_above;
        logic vout_word;
        logic vout_minmax_warn;
        logic cml_invalid_data;
    } vfs_status_type;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] cmd;
        logic [15:0] data;
    } vfs_req_type;
endpackage : vfs_pkg

/* File: hw/vfs_freq_decode.sv */
`timescale 1ns/10ps
module vfs_freq_decode (
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire logic [3:0] mant_in,
    input wire logic strap_in,
    output vfs_pkg::vfs_freq_type freq_out
);
    wire logic [3:0] m;
    vfs_pkg::vfs_freq_type f_d;
    vfs_pkg::vfs_freq_type f_q;
    assign m = mant_in;
    // Strap limits to 0.6, 0.8, 1.0 or 1.4 MHz.
    always_comb begin
        if (m < 4'h4) f_d = strap_in ? vfs_pkg::VFS_F0P6 : vfs_pkg::VFS_F0P4;
        else if (m < 4'h6) f_d = vfs_pkg::VFS_F0P6;
        else if (m < 4'h7) f_d = vfs_pkg::VFS_F0P8;
        else if (m < 4'h9) f_d = vfs_pkg::VFS_F1P0;
        else if (m < 4'hA) f_d = strap_in ? vfs_pkg::VFS_F1P0 : vfs_pkg::VFS_F1P2;
        else if (m < 4'hD) f_d = vfs_pkg::VFS_F1P4;
        else if (m < 4'hF) f_d = strap_in ? vfs_pkg::VFS_F1P4 : vfs_pkg::VFS_F1P8;
        else f_d = strap_in ? vfs_pkg::VFS_F1P4 : vfs_pkg::VFS_F2P0;
    end
    always_ff @(posedge clock_in) begin
        if (!nrst_in) f_q <= vfs_pkg::VFS_F0P4;
        else f_q <= f_d; // R11 R13
    end
    assign freq_out = f_q;
endmodule : vfs_freq_decode

/* File: bench/vfs_regs_properties.sv */
`timescale 1ns/10ps
module vfs_regs_chk (
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] cmd_in,
    input wire logic [15:0] wdata_in,
    input wire logic [3:0] scale_mant_in,
    input wire logic [15:0] rdata_out,
    input wire vfs_pkg::vfs_freq_type freq_out,
    input wire vfs_pkg::vfs_status_type status_out,
    input wire logic notify_out,
    input wire logic [3:0] scale_restore_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!nrst_in);
    sequence s_rd(c);
        rd_in && cmd_in == c;
    endsequence
    sequence s_wr(c);
        wr_in && cmd_in == c;
    endsequence
    a_floor_hi_zero: assert property (s_rd(8'h2B) |=> rdata_out[15:12] == 4'h0)
        else $error("floor upper bits not zero");
    a_freq_fixed: assert property (s_rd(8'h33) |=> rdata_out[15:4] == 12'h380)
        else $error("frequency fixed bits wrong");
    a_freq_hot: assert property ($onehot(freq_out))
        else $error("frequency select not one-hot");
    a_bad_freq: assert property (s_wr(8'h33) && wdata_in[15:4] != 12'h380
        |-> ##[1:2] status_out.cml_invalid_data)
        else $error("bad frequency write not flagged");
    a_bad_floor: assert property (s_wr(8'h2B) && wdata_in[15:12] != 4'h0
        |-> ##[1:2] status_out.cml_invalid_data)
        else $error("bad floor write not flagged");
    a_warn_bits: assert property ($rose(status_out.vout_minmax_warn)
        |-> status_out.none_of_above && status_out.vout_word ##[0:1] notify_out)
        else $error("warning status or notify missing");
    a_notify_pulse: assert property (notify_out |=> !notify_out)
        else $error("notify longer than one cycle");
    a_scale_map: assert property (1'b1 |=> scale_restore_out ==
        ($past(scale_mant_in[3]) ? 4'h8 : 4'h0))
        else $error("scale restore wrong");
endmodule : vfs_regs_chk
bind vfs_regs vfs_regs_chk u_chk (.*);

/* File: bench/vfs_host_model.sv */
`timescale 1ns/10ps
module vfs_host_model (
    input wire logic clock_in,
    output logic wr_out,
    output logic rd_out,
    output logic [7:0] cmd_out,
    output logic [15:0] wdata_out
);
    initial begin
        wr_out = 1'b0;
        rd_out = 1'b0;
        cmd_out = 8'h00;
        wdata_out = 16'h0000;
    end
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d);
        @(negedge clock_in);
        wr_out = w;
        rd_out = !w;
        cmd_out = c;
        wdata_out = d;
        @(negedge clock_in);
        wr_out = 1'b0;
        rd_out = 1'b0;
        wdata_out = ~d;
    endtask : xfer
endmodule : vfs_host_model

/* File: bench/vfs_regs_test.sv */
`timescale 1ns/10ps
module vfs_regs_test;
    logic clock_in, nrst_in, wr, rd, conv, strap_sel, ramp, notify;
    logic [7:0] cmd, lfsr;
    logic [15:0] wdata, rdata;
    logic [11:0] vout, fl;
    logic [3:0] smant, rest;
    vfs_pkg::vfs_freq_type freq;
    vfs_pkg::vfs_status_type status;
    int miscompares, checks_done;
    vfs_host_model u_host (.clock_in(clock_in), .wr_out(wr), .rd_out(rd), .cmd_out(cmd),
        .wdata_out(wdata));
    vfs_regs u_dut (.clock_in(clock_in), .nrst_in(nrst_in), .wr_in(wr), .rd_in(rd),
        .cmd_in(cmd), .wdata_in(wdata), .converting_in(conv), .target_in(12'h010),
        .nvm_floor_in(12'h000), .nvm_freq_in(4'h9), .use_strap_in(strap_sel),
        .second_strap_selector_in(4'h5), .scale_mant_in(smant), .rdata_out(rdata),
        .vout_cmd_out(vout), .ramp_out(ramp), .freq_out(freq), .status_out(status),
        .notify_out(notify), .scale_restore_out(rest));
    function automatic logic [7:0] nx(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : nx
    function automatic logic [7:0] expf(input logic [3:0] m);
        if (m < 4) return 8'h01;
        if (m < 6) return 8'h02;
        if (m < 7) return 8'h04;
        if (m < 9) return 8'h08;
        if (m < 10) return 8'h10;
        if (m < 13) return 8'h20;
        if (m < 15) return 8'h40;
        return 8'h80;
    endfunction : expf
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic rst(input logic s);
        @(negedge clock_in);
        nrst_in = 1'b0;
        strap_sel = s;
        repeat (8) @(negedge clock_in);
        nrst_in = 1'b1;
        repeat (11) @(negedge clock_in);
    endtask : rst
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        clock_in = 1'b0;
        forever #20 clock_in = ~clock_in;
    end
    initial begin
        nrst_in = 1'b0;
        conv = 1'b0;
        smant = 4'h0;
        lfsr = 8'h44;
        strap_sel = 1'b1;
        miscompares = 0;
        checks_done = 0;
        rst(1'b1);
        chk({8'h00, freq}, 16'h0002);
        rst(1'b0);
        chk({8'h00, freq}, 16'h0010);
        $display("startup test done");
        for (int m = 0; m < 16; m++) begin
            smant = lfsr[3:0];
            lfsr = nx(lfsr);
            u_host.xfer(1'b1, 8'h33, 16'h3800 | m[15:0]);
            u_host.xfer(1'b0, 8'h33, 16'h0000);
            chk(rdata, 16'h3800 | m[15:0]);
            chk({8'h00, freq}, {8'h00, expf(m[3:0])});
        end
        u_host.xfer(1'b1, 8'h33, {lfsr, 8'hF5});
        chk({15'h0000, notify}, 16'h0001);
        u_host.xfer(1'b0, 8'h33, 16'h0000);
        chk(rdata, 16'h380F);
        chk({15'h0000, status.cml_invalid_data}, 16'h0001);
        $display("frequency test done");
        fl = {4'h1, lfsr};
        conv = 1'b1;
        u_host.xfer(1'b1, 8'h2B, {4'h0, fl});
        u_host.xfer(1'b1, 8'h2B, 16'hA000);
        u_host.xfer(1'b0, 8'h2B, 16'h0000);
        chk(rdata, {4'h0, fl});
        for (int i = 0; i < 600 && (ramp || vout !== fl); i++) @(negedge clock_in);
        chk({4'h0, vout}, {4'h0, fl});
        chk({12'h000, status}, 16'h000F);
        $display("floor test done");
        tally_and_finish();
    end
endmodule : vfs_regs_test
